// ===== design/cvl_lcd_front.sv
// lcd end: samples serial crt video and drives lcd lanes and row clocks
`default_nettype none
module cvl_lcd_front import cvl_pkg::*; #(
	parameter int HCNT_W = 12,
	parameter int LCNT_W = 11
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	cvl_video_if.device vid,
	input wire logic sample_edge_select_i,
	input wire logic vsync_polarity_select_i,
	input wire logic width_select_i,
	input wire logic adjust_target_select_i,
	input wire logic [3:0] fine_adjust_inputs_i,
	input wire logic [2:0] line_count_select_i,
	input wire logic [1:0] program_method_select_i,
	input wire logic [3:0] display_mode_select_i,
	input wire logic internal_strobe_select_i,
	input wire logic [8:0] reg_chars_i,
	input wire logic [10:0] reg_lines_i,
	input wire logic [31:0] gray_palette_i,
	input wire logic lane_ready_i,
	output logic lane_valid_o,
	output logic [3:0] upper_panel_lane_o,
	output logic [3:0] lower_panel_lane_o,
	output logic [3:0] blue_lane_o,
	output logic column_shift_clock_o,
	output logic line_latch_clock_o,
	output logic row_clock_single_side_o,
	output logic row_clock_dual_side_o,
	output logic frame_start_marker_o,
	output logic alternation_o,
	output logic buffer_write_strobe_o,
	output logic buffer_red_o,
	output logic buffer_green_o,
	output logic buffer_blue_o,
	output logic display_enable_o,
	output logic config_error_o,
	output logic overrun_o
);
	if (HCNT_W != 12 || LCNT_W != 11) begin : g_chk
		$error("counter widths must be 12 and 11 bits");
	end
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [CVL_SYNC_W-1:0] raw, s1, s2;
	assign raw = {vid.external_reset_n, vid.dot_clk, vid.red, vid.green, vid.blue, vid.hsync,
		vid.vsync, vid.disp_strobe, internal_strobe_select_i, sample_edge_select_i,
		vsync_polarity_select_i, width_select_i, adjust_target_select_i,
		fine_adjust_inputs_i, line_count_select_i, program_method_select_i,
		display_mode_select_i};
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s1 <= '0;
			s2 <= '0;
		end else if (clk_en_i) begin
			s1 <= raw;
			s2 <= s1;
		end
	end
	logic ext_rst_n, dot_s, r_s, g_s, b_s, hs_s, vs_s, de_s;
	logic int_sel, edge_sel, pol_sel, wid_sel, adj_sel;
	logic [3:0] fine_s, dm_s;
	logic [2:0] lc_s;
	logic [1:0] pm_s;
	assign {ext_rst_n, dot_s, r_s, g_s, b_s, hs_s, vs_s, de_s, int_sel, edge_sel, pol_sel,
		wid_sel, adj_sel, fine_s, lc_s, pm_s, dm_s} = s2;
	// ----------------------------------------
	// configuration latch
	// ----------------------------------------
	logic loaded, next_loaded, c_edge, next_c_edge, c_pol, next_c_pol, c_adj, next_c_adj;
	logic c_int, next_c_int, c_dside, next_c_dside, c_dpanel, next_c_dpanel;
	logic c_en, next_c_en, c_err, next_c_err;
	logic [3:0] c_fine, next_c_fine;
	logic [8:0] c_chars, next_c_chars;
	logic [10:0] c_lines, next_c_lines, base_lines;
	cvl_mode_e c_mode, next_c_mode;
	always_comb begin
		next_loaded = ext_rst_n;
		{next_c_edge, next_c_pol, next_c_adj, next_c_int} = {c_edge, c_pol, c_adj, c_int};
		{next_c_dside, next_c_dpanel, next_c_en, next_c_err} = {c_dside, c_dpanel, c_en, c_err};
		next_c_fine = c_fine;
		next_c_chars = c_chars;
		next_c_lines = c_lines;
		next_c_mode = c_mode;
		base_lines = (lc_s < CVL_LINE_CODES) ? CVL_LINE_TABLE[lc_s] : CVL_LINES_INHIBIT;
		if (!loaded) begin
			{next_c_edge, next_c_pol, next_c_adj, next_c_int} = {edge_sel, pol_sel, adj_sel,
				int_sel};
			next_c_fine = fine_s;
			next_c_mode = (dm_s[3:2] == 2'h0) ? CVL_MONO :
				(dm_s[3:2] == 2'h1) ? CVL_GRAY : CVL_COLOR;
			next_c_dside = dm_s[0];
			next_c_dpanel = dm_s[1];
			if (pm_s == CVL_PM_PINS) begin
				next_c_chars = wid_sel ? CVL_CHARS_WIDE : CVL_CHARS_NARROW;
				next_c_lines = 11'(base_lines + (adj_sel ? 11'h000 : {7'h00, fine_s}));
				next_c_err = (lc_s >= CVL_LINE_CODES);
			end else begin
				next_c_chars = reg_chars_i;
				next_c_lines = reg_lines_i;
				next_c_err = reg_chars_i < CVL_CHARS_MIN || reg_chars_i > CVL_CHARS_MAX ||
					reg_lines_i < CVL_LINES_MIN || reg_lines_i > CVL_LINES_MAX;
			end
			next_c_en = next_loaded && (pm_s != CVL_PM_TEST) && !next_c_err;
		end
	end
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			loaded <= 1'b0;
			{c_edge, c_pol, c_adj, c_int, c_dside, c_dpanel, c_en, c_err} <= 8'h00;
			c_fine <= 4'h0;
			c_chars <= CVL_RST_CHARS;
			c_lines <= CVL_RST_LINES;
			c_mode <= CVL_MONO;
		end else if (clk_en_i) begin
			loaded <= next_loaded;
			{c_edge, c_pol, c_adj, c_int} <= {next_c_edge, next_c_pol, next_c_adj, next_c_int};
			{c_dside, c_dpanel, c_en, c_err} <= {next_c_dside, next_c_dpanel, next_c_en,
				next_c_err};
			c_fine <= next_c_fine;
			c_chars <= next_c_chars;
			c_lines <= next_c_lines;
			c_mode <= next_c_mode;
		end
	end
	// ----------------------------------------
	// timing and pixel assembly
	// ----------------------------------------
	logic dot_q, hs_q, vs_q, alt, next_alt, latch_p, next_latch_p, frame_start_marker, next_flm;
	logic wr_p, next_wr_p, br, next_br, bg, next_bg, bb, next_bb;
	logic [11:0] hcnt, next_hcnt, hbeg, hend;
	logic [10:0] lcnt, next_lcnt;
	logic [3:0] rsh, next_rsh, gsh, next_gsh, bsh, next_bsh, level;
	logic [1:0] pcnt, next_pcnt;
	logic smp, vs_act, hs_st, vs_st, de, mono_px, push;
	logic [11:0] word;
	always_comb begin
		smp = c_edge ? (!dot_s && dot_q) : (dot_s && !dot_q);
		vs_act = c_pol ? vs_s : ~vs_s;
		hs_st = smp && hs_s && !hs_q;
		vs_st = smp && vs_act && !vs_q;
		hbeg = c_adj ? {8'h00, c_fine} : 12'h000;
		hend = 12'(hbeg + {c_chars, 3'h0});
		de = c_int ? (hcnt >= hbeg && hcnt < hend && lcnt != 11'h000 && lcnt <= c_lines)
			: de_s;
		mono_px = r_s | g_s | b_s;
		level = gray_palette_i[{r_s, g_s, b_s, 2'h0} +: 4];
		if (level > CVL_GRAY_MAX) begin
			level = CVL_GRAY_MAX;
		end
		next_hcnt = hs_st ? 12'h000 : (smp && hcnt != 12'hFFF) ? 12'(hcnt + 12'h001) : hcnt;
		next_lcnt = vs_st ? 11'h000 : (hs_st && lcnt != 11'h7FF) ? 11'(lcnt + 11'h001) : lcnt;
		next_alt = (vs_st && c_en) ? ~alt : alt;
		next_latch_p = hs_st && c_en;
		next_flm = hs_st && c_en && lcnt == 11'h000;
		next_rsh = rsh;
		next_gsh = gsh;
		next_bsh = bsh;
		next_pcnt = pcnt;
		push = 1'b0;
		word = 12'h000;
		next_wr_p = smp && de && c_en;
		next_br = br;
		next_bg = bg;
		next_bb = bb;
		if (next_wr_p) begin
			next_br = (c_mode == CVL_COLOR) ? r_s : mono_px;
			next_bg = g_s;
			next_bb = b_s;
			next_rsh = {rsh[2:0], (c_mode == CVL_COLOR) ? r_s : mono_px};
			next_gsh = {gsh[2:0], g_s};
			next_bsh = {bsh[2:0], b_s};
			next_pcnt = 2'(pcnt + 2'h1);
			if (c_mode == CVL_GRAY) begin
				push = 1'b1;
				word = {level, 8'h00};
			end else if (pcnt == 2'h3) begin
				push = 1'b1;
				word = (c_mode == CVL_COLOR) ? {next_rsh, next_gsh, next_bsh}
					: {next_rsh, 8'h00};
			end
			// lower half of a split panel rides the second lane
			if (c_mode != CVL_COLOR && c_dpanel && lcnt > {1'b0, c_lines[10:1]}) begin
				word = {4'h0, word[11:8], 4'h0};
			end
		end
		if (hs_st) begin
			next_pcnt = 2'h0;
		end
	end
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			{dot_q, hs_q, vs_q, alt, latch_p, frame_start_marker, wr_p, br, bg, bb} <= 10'h000;
			hcnt <= 12'h000;
			lcnt <= 11'h000;
			{rsh, gsh, bsh} <= 12'h000;
			pcnt <= 2'h0;
		end else if (clk_en_i) begin
			dot_q <= dot_s;
			if (smp) begin
				hs_q <= hs_s;
				vs_q <= vs_act;
			end
			{alt, latch_p, frame_start_marker, wr_p, br, bg, bb} <= {next_alt, next_latch_p, next_flm,
				next_wr_p, next_br, next_bg, next_bb};
			hcnt <= next_hcnt;
			lcnt <= next_lcnt;
			{rsh, gsh, bsh} <= {next_rsh, next_gsh, next_bsh};
			pcnt <= next_pcnt;
		end
	end
	// ----------------------------------------
	// two-entry lane buffer
	// ----------------------------------------
	logic [11:0] mem [2];
	logic [11:0] next_mem [2];
	logic wp, next_wp, rp, next_rp, ovr, next_ovr, pop;
	logic [1:0] cnt, next_cnt;
	always_comb begin
		// the video cannot be stalled, so a full buffer drops and flags
		pop = lane_ready_i && cnt != 2'h0 && clk_en_i;
		next_mem = mem;
		next_wp = wp;
		// a reload clears the flag, but a drop in that same cycle still sets it
		next_ovr = (ovr && loaded) || (push && cnt == 2'h2 && !pop);
		if (push && (cnt != 2'h2 || pop)) begin
			next_mem[wp] = word;
			next_wp = ~wp;
		end
		next_rp = pop ? ~rp : rp;
		next_cnt = 2'(cnt + {1'b0, push && (cnt != 2'h2 || pop)} - {1'b0, pop});
	end
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mem <= '{12'h000, 12'h000};
			{wp, rp, ovr} <= 3'h0;
			cnt <= 2'h0;
		end else if (clk_en_i) begin
			mem <= next_mem;
			{wp, rp, ovr} <= {next_wp, next_rp, next_ovr};
			cnt <= next_cnt;
		end
	end
	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign lane_valid_o = cnt != 2'h0;
	assign {upper_panel_lane_o, lower_panel_lane_o, blue_lane_o} = mem[rp];
	assign column_shift_clock_o = pop;
	assign line_latch_clock_o = latch_p;
	assign row_clock_single_side_o = latch_p && !c_dside;
	assign row_clock_dual_side_o = latch_p && c_dside;
	assign frame_start_marker_o = frame_start_marker;
	assign alternation_o = alt;
	assign buffer_write_strobe_o = wr_p;
	assign buffer_red_o = br;
	assign buffer_green_o = bg;
	assign buffer_blue_o = bb;
	assign display_enable_o = c_en;
	assign config_error_o = c_err;
	assign overrun_o = ovr;
endmodule
`default_nettype wire

// ===== include/cvl_pkg.sv
// shared constants for the crt video to lcd front end
`default_nettype none
package cvl_pkg;
	// ----------------------------------------
	// clocking and dot grouping
	// ----------------------------------------
	localparam int CVL_CLK_MHZ = 200;
	localparam int CVL_CHAR_DOTS = 8;
	localparam int CVL_LANE_W = 4;
	localparam int CVL_SYNC_W = 26;
	localparam int CVL_DOT_PERIOD_NS = 50;
	localparam int CVL_DOT_HALF = (CVL_DOT_PERIOD_NS * CVL_CLK_MHZ) / 2000;
	localparam logic [3:0] CVL_EXT_RST_DOTS = 4'h4;
	// ----------------------------------------
	// program method codes
	// ----------------------------------------
	localparam logic [1:0] CVL_PM_PINS = 2'h0;
	localparam logic [1:0] CVL_PM_MPU = 2'h1;
	localparam logic [1:0] CVL_PM_ROM = 2'h2;
	localparam logic [1:0] CVL_PM_TEST = 2'h3;
	// ----------------------------------------
	// screen size
	// ----------------------------------------
	localparam logic [8:0] CVL_CHARS_NARROW = 9'h050;
	localparam logic [8:0] CVL_CHARS_WIDE = 9'h05A;
	localparam logic [8:0] CVL_CHARS_MIN = 9'h004;
	localparam logic [8:0] CVL_CHARS_MAX = 9'h1FA;
	localparam logic [10:0] CVL_LINES_MIN = 11'h004;
	localparam logic [10:0] CVL_LINES_MAX = 11'h400;
	localparam logic [2:0] CVL_LINE_CODES = 3'h6;
	localparam logic [10:0] CVL_LINES_INHIBIT = 11'h1E0;
	localparam logic [10:0] CVL_LINE_TABLE [6] = '{11'h0C8, 11'h15E, 11'h190, 11'h1E0,
		11'h200, 11'h21C};
	localparam logic [3:0] CVL_GRAY_MAX = 4'hC;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [8:0] CVL_RST_CHARS = 9'h050;
	localparam logic [10:0] CVL_RST_LINES = 11'h0C8;
	typedef enum logic [1:0] {CVL_MONO, CVL_GRAY, CVL_COLOR} cvl_mode_e;
endpackage
`default_nettype wire

// ===== include/cvl_video_if.sv
// video link between the crt graphics source and the lcd front end
`default_nettype none
interface cvl_video_if;
	logic dot_clk;
	logic red;
	logic green;
	logic blue;
	logic hsync;
	logic vsync;
	logic disp_strobe;
	logic external_reset_n;
	modport source (output dot_clk, red, green, blue, hsync, vsync, disp_strobe,
		external_reset_n);
	modport device (input dot_clk, red, green, blue, hsync, vsync, disp_strobe,
		external_reset_n);
endinterface
`default_nettype wire

// ===== design/cvl_crt_source.sv
// crt graphics source end: makes the dot clock and launches serial video
`default_nettype none
module cvl_crt_source import cvl_pkg::*; (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	cvl_video_if.source vid,
	input wire logic dot_valid_i,
	output logic dot_ready_o,
	input wire logic dot_red_i,
	input wire logic dot_green_i,
	input wire logic dot_blue_i,
	input wire logic dot_hsync_i,
	input wire logic dot_vsync_i,
	input wire logic dot_disp_i,
	input wire logic mono_i,
	input wire logic internal_strobe_i,
	input wire logic sample_on_fall_i
);
	if (CVL_DOT_HALF < 2) begin : g_chk
		$error("dot half period too short for the sampling end");
	end
	// ----------------------------------------
	// dot clock divider and launch
	// ----------------------------------------
	logic [7:0] div_cnt, next_div_cnt;
	logic dot, next_dot, tgl, launch;
	logic [6:0] pins, next_pins;
	logic [3:0] rst_cnt, next_rst_cnt;
	always_comb begin
		tgl = (div_cnt == 8'(CVL_DOT_HALF - 1));
		next_div_cnt = tgl ? 8'h00 : 8'(div_cnt + 8'h01);
		next_dot = tgl ? ~dot : dot;
		// launch half a dot before the sampling edge
		launch = tgl && (next_dot == sample_on_fall_i);
		next_pins = pins;
		next_rst_cnt = rst_cnt;
		if (launch && rst_cnt != CVL_EXT_RST_DOTS) begin
			next_rst_cnt = rst_cnt + 4'h1;
		end
		if (launch) begin
			next_pins = 7'h00;
			if (dot_valid_i) begin
				next_pins[6] = dot_red_i;
				next_pins[5] = dot_green_i & ~mono_i;
				next_pins[4] = dot_blue_i & ~mono_i;
				next_pins[3] = dot_hsync_i;
				next_pins[2] = dot_vsync_i;
				// fixed low while the far end makes its own strobe
				next_pins[1] = dot_disp_i & ~internal_strobe_i;
			end
			next_pins[0] = (rst_cnt == CVL_EXT_RST_DOTS);
		end
	end
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			div_cnt <= 8'h00;
			dot <= 1'b0;
			pins <= 7'h00;
			rst_cnt <= 4'h0;
		end else if (clk_en_i) begin
			div_cnt <= next_div_cnt;
			dot <= next_dot;
			pins <= next_pins;
			rst_cnt <= next_rst_cnt;
		end
	end
	assign dot_ready_o = launch && clk_en_i;
	assign vid.dot_clk = dot;
	assign vid.red = pins[6];
	assign vid.green = pins[5];
	assign vid.blue = pins[4];
	assign vid.hsync = pins[3];
	assign vid.vsync = pins[2];
	assign vid.disp_strobe = pins[1];
	assign vid.external_reset_n = pins[0];
endmodule
`default_nettype wire

// ===== test/cvl_link_monitor.sv
// checker for the video link and lane side of the crt to lcd front end
`default_nettype none
module cvl_link_monitor (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic dot_clk,
	input wire logic green,
	input wire logic blue,
	input wire logic hsync,
	input wire logic vsync,
	input wire logic disp_strobe,
	input wire logic mono_i,
	input wire logic internal_strobe_i,
	input wire logic sample_edge_select_i,
	input wire logic vsync_polarity_select_i,
	input wire logic lane_ready_i,
	input wire logic lane_valid_o,
	input wire logic column_shift_clock_o,
	input wire logic [3:0] upper_panel_lane_o,
	input wire logic [3:0] lower_panel_lane_o,
	input wire logic [3:0] blue_lane_o,
	input wire logic line_latch_clock_o,
	input wire logic frame_start_marker_o,
	input wire logic alternation_o,
	input wire logic buffer_write_strobe_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// ----------------------------------------
	// link side
	// ----------------------------------------
	// config pins only move under reset, so the raw pin is a fair reference
	property p_edge_pick;
		buffer_write_strobe_o |-> $past(dot_clk, 2) == !sample_edge_select_i;
	endproperty
	a_edge_pick: assert property (p_edge_pick) else $error("dot taken on wrong edge");
	property p_alt_on_vsync;
		$changed(alternation_o) |-> vsync == vsync_polarity_select_i;
	endproperty
	a_alt_on_vsync: assert property (p_alt_on_vsync) else $error("alternation off vsync");
	property p_strobe_quiet;
		internal_strobe_i |-> !disp_strobe;
	endproperty
	a_strobe_quiet: assert property (p_strobe_quiet) else $error("strobe not held");
	property p_mono_low;
		mono_i |-> !green && !blue;
	endproperty
	a_mono_low: assert property (p_mono_low) else $error("green or blue lit in mono");
	// ----------------------------------------
	// lane and row side
	// ----------------------------------------
	property p_pop;
		column_shift_clock_o == (lane_valid_o && lane_ready_i && clk_en_i);
	endproperty
	a_pop: assert property (p_pop) else $error("shift clock not equal to pop");
	property p_hold;
		lane_valid_o && !lane_ready_i |=> lane_valid_o && $stable(upper_panel_lane_o)
			&& $stable(lower_panel_lane_o) && $stable(blue_lane_o);
	endproperty
	a_hold: assert property (p_hold) else $error("lane word moved while stalled");
	property p_latch_hsync;
		line_latch_clock_o |-> hsync;
	endproperty
	a_latch_hsync: assert property (p_latch_hsync) else $error("line latch off hsync");
	property p_marker;
		frame_start_marker_o |-> line_latch_clock_o;
	endproperty
	a_marker: assert property (p_marker) else $error("marker without line latch");
	property p_alt_steady;
		$changed(alternation_o) |=> $stable(alternation_o)[*8];
	endproperty
	a_alt_steady: assert property (p_alt_steady) else $error("alternation chatters");
endmodule
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench: crt source and lcd front end joined by the link
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, sys_rst_i, dot_valid, dr, dg, db, dh, dv, dd, mono, istb, edg, vpol, lready;
	logic [3:0] dmode;
	logic [1:0] pm;
	logic [2:0] ls;
	logic [8:0] rc;
	logic [31:0] pal;
	logic ce, wr_r, wr_g, wr_b;
	logic rdy, lvalid, shift, latch, r1, r2, mark, alt, bws, en, err, ovr, a0;
	logic [3:0] up, lo, bl;
	logic [11:0] q[$];
	int bad_count, n_checks, nlat, nmark, n1, n2, nbr, nbg, nbb, nlines;
	cvl_video_if cvl_video_if_i();
	cvl_crt_source cvl_crt_source_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(ce),
		.vid(cvl_video_if_i), .dot_valid_i(dot_valid), .dot_ready_o(rdy), .dot_red_i(dr),
		.dot_green_i(dg), .dot_blue_i(db), .dot_hsync_i(dh), .dot_vsync_i(dv), .dot_disp_i(dd),
		.mono_i(mono), .internal_strobe_i(istb), .sample_on_fall_i(edg));
	cvl_lcd_front cvl_lcd_front_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(ce),
		.vid(cvl_video_if_i), .sample_edge_select_i(edg), .vsync_polarity_select_i(vpol),
		.width_select_i(1'b0), .adjust_target_select_i(1'b0), .fine_adjust_inputs_i(4'h0),
		.line_count_select_i(ls), .program_method_select_i(pm), .display_mode_select_i(dmode),
		.internal_strobe_select_i(istb), .reg_chars_i(rc), .reg_lines_i(11'h004),
		.gray_palette_i(pal), .lane_ready_i(lready), .lane_valid_o(lvalid),
		.upper_panel_lane_o(up), .lower_panel_lane_o(lo), .blue_lane_o(bl),
		.column_shift_clock_o(shift), .line_latch_clock_o(latch), .row_clock_single_side_o(r1),
		.row_clock_dual_side_o(r2), .frame_start_marker_o(mark), .alternation_o(alt),
		.buffer_write_strobe_o(bws), .buffer_red_o(wr_r), .buffer_green_o(wr_g),
		.buffer_blue_o(wr_b),
		.display_enable_o(en), .config_error_o(err), .overrun_o(ovr));
	cvl_link_monitor cvl_link_monitor_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(ce),
		.dot_clk(cvl_video_if_i.dot_clk), .green(cvl_video_if_i.green),
		.blue(cvl_video_if_i.blue), .hsync(cvl_video_if_i.hsync), .vsync(cvl_video_if_i.vsync),
		.disp_strobe(cvl_video_if_i.disp_strobe), .mono_i(mono), .internal_strobe_i(istb),
		.sample_edge_select_i(edg), .vsync_polarity_select_i(vpol), .lane_ready_i(lready),
		.lane_valid_o(lvalid), .column_shift_clock_o(shift), .upper_panel_lane_o(up),
		.lower_panel_lane_o(lo), .blue_lane_o(bl), .line_latch_clock_o(latch),
		.frame_start_marker_o(mark), .alternation_o(alt), .buffer_write_strobe_o(bws));
	// ----------------------------------------
	// clock, observers, checks
	// ----------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// registered pulses are counted mid-cycle so each is seen once
	always @(negedge clk_i) begin
		if (shift === 1'b1) q.push_back({up, lo, bl});
		if (latch === 1'b1) nlat++;
		if (mark === 1'b1) nmark++;
		if (r1 === 1'b1) n1++;
		if (r2 === 1'b1) n2++;
		if (bws === 1'b1 && wr_r === 1'b1) nbr++;
		if (bws === 1'b1 && wr_g === 1'b1) nbg++;
		if (bws === 1'b1 && wr_b === 1'b1) nbb++;
	end
	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// link driver
	// ----------------------------------------
	// d = {r, g, b, hsync, vsync, strobe}; the stream never stalls, valid stays up
	task send_dot(input logic [5:0] d);
		int k;
		{dr, dg, db, dh, dv, dd} <= d;
		dot_valid <= 1'b1;
		k = 0;
		@(negedge clk_i);
		while (rdy !== 1'b1 && k < 100) begin
			@(negedge clk_i);
			k++;
		end
		if (rdy !== 1'b1) bad_count++;
		@(posedge clk_i);
	endtask
	function automatic logic [2:0] pix(input logic [11:0] p, input int j);
		return {p[11 - j % 4], p[7 - j % 4], p[3 - j % 4]};
	endfunction
	function automatic logic [3:0] lvl(input logic [2:0] idx);
		logic [3:0] v;
		v = pal[idx * 4 +: 4];
		return (v > 4'hC) ? 4'hC : v;
	endfunction
	task cfg(input logic [3:0] dm, input logic [1:0] p, input logic [2:0] l,
		input logic [8:0] c, input logic m, input logic s, input logic e, input logic v);
		int k;
		sys_rst_i <= 1'b1;
		{dmode, pm, ls, rc, mono, istb, edg, vpol} <= {dm, p, l, c, m, s, e, v};
		{dr, dg, db, dh, dv, dd} <= {4'h0, !v, 1'b0};
		repeat (10) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		k = 0;
		while (cvl_video_if_i.external_reset_n !== 1'b1 && k < 1000) begin
			@(posedge clk_i);
			k++;
		end
		if (cvl_video_if_i.external_reset_n !== 1'b1) bad_count++;
		repeat (100) @(posedge clk_i);
		q.delete();
		{nlat, nmark, n1, n2, nbr, nbg, nbb} = '0;
		a0 = alt;
	endtask
	// vsync pulse then nlines lines of 32 displayed dots
	task frame(input logic [11:0] p);
		int l;
		int j;
		repeat (2) send_dot({4'h0, vpol, 1'b0});
		for (l = 0; l < nlines; l++) begin
			repeat (2) send_dot({4'h1, !vpol, 1'b0});
			repeat (2) send_dot({4'h0, !vpol, 1'b0});
			for (j = 0; j < 32; j++) send_dot({pix(p, j), 1'b0, !vpol, 1'b1});
			repeat (8) send_dot({4'h0, !vpol, 1'b0});
		end
		repeat (100) @(posedge clk_i);
	endtask
	task run_colour(input logic [3:0] dm, input logic e, input logic v);
		cfg(dm, 2'h1, 3'h0, 9'h004, 1'b0, 1'b0, e, v);
		chk("enable", 16'h1, {15'h0, en});
		chk("cfg_err", 16'h0, {15'h0, err});
		frame(12'h96C);
		chk("words", 16'h10, 16'(q.size()));
		foreach (q[i]) chk("colour", 16'h096C, {4'h0, q[i]});
		chk("latches", 16'h2, 16'(nlat));
		chk("marker", 16'h1, 16'(nmark));
		chk("single", dm[0] ? 16'h0 : 16'h2, 16'(n1));
		chk("dual", dm[0] ? 16'h2 : 16'h0, 16'(n2));
		chk("alt", {15'h0, !a0}, {15'h0, alt});
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		{dot_valid, dr, dg, db, dh, dv, dd, mono, istb, edg, vpol} = '0;
		{bad_count, n_checks, nlat, nmark, n1, n2, nbr, nbg, nbb} = '0;
		nlines = 2;
		ce = 1'b1;
		sys_rst_i = 1'b1;
		lready = 1'b1;
		{dmode, pm, ls, rc} = {4'h8, 2'h1, 3'h0, 9'h004};
		pal = 32'hFD975310;
		run_colour(4'h8, 1'b1, 1'b1);
		run_colour(4'h9, 1'b0, 1'b0);
		cfg(4'h0, 2'h1, 3'h0, 9'h004, 1'b0, 1'b0, 1'b1, 1'b1);
		frame(12'h842);
		chk("mono_words", 16'h10, 16'(q.size()));
		foreach (q[i]) chk("mono_or", 16'hE, {12'h0, q[i][11:8]});
		chk("red_plane", 16'h30, 16'(nbr));
		chk("green_plane", 16'h10, 16'(nbg));
		chk("blue_plane", 16'h10, 16'(nbb));
		cfg(4'h4, 2'h1, 3'h0, 9'h004, 1'b0, 1'b0, 1'b1, 1'b1);
		frame(12'hC5A);
		chk("gray_words", 16'h40, 16'(q.size()));
		foreach (q[i]) chk("gray", {12'h0, lvl(pix(12'hC5A, i))}, {12'h0, q[i][11:8]});
		cfg(4'h0, 2'h1, 3'h0, 9'h004, 1'b1, 1'b1, 1'b1, 1'b1);
		frame(12'hF0F);
		chk("int_words", 16'h10, 16'(q.size()));
		cfg(4'h8, 2'h1, 3'h0, 9'h004, 1'b0, 1'b0, 1'b1, 1'b1);
		lready <= 1'b0;
		frame(12'h96C);
		chk("overrun", 16'h1, {15'h0, ovr});
		chk("full", 16'h1, {15'h0, lvalid});
		// a frozen block must not pop even with ready up
		ce <= 1'b0;
		lready <= 1'b1;
		repeat (20) @(posedge clk_i);
		chk("frozen", 16'h0, 16'(q.size()));
		chk("held", 16'h1, {15'h0, lvalid});
		ce <= 1'b1;
		repeat (20) @(posedge clk_i);
		chk("kept", 16'h2, 16'(q.size()));
		chk("empty", 16'h0, {15'h0, lvalid});
		nlines = 4;
		cfg(4'h2, 2'h2, 3'h0, 9'h004, 1'b0, 1'b0, 1'b1, 1'b1);
		chk("rom_en", 16'h1, {15'h0, en});
		frame(12'h842);
		chk("split_words", 16'h20, 16'(q.size()));
		foreach (q[i]) chk("split", (i < 16) ? 16'h0E00 : 16'h00E0, {4'h0, q[i]});
		nlines = 2;
		cfg(4'h8, 2'h0, 3'h6, 9'h004, 1'b0, 1'b0, 1'b1, 1'b1);
		chk("inhibit", 16'h1, {15'h0, err});
		cfg(4'h8, 2'h0, 3'h3, 9'h004, 1'b0, 1'b0, 1'b1, 1'b1);
		chk("pins_ok", 16'h0, {15'h0, err});
		chk("pins_en", 16'h1, {15'h0, en});
		cfg(4'h8, 2'h3, 3'h0, 9'h004, 1'b0, 1'b0, 1'b1, 1'b1);
		chk("test_off", 16'h0, {15'h0, en});
		cfg(4'h8, 2'h1, 3'h0, 9'h003, 1'b0, 1'b0, 1'b1, 1'b1);
		chk("small", 16'h1, {15'h0, err});
		close_out();
	end
	initial begin
		repeat (60000) @(posedge clk_i);
		bad_count++;
		close_out();
	end
endmodule
`default_nettype wire
